// ### src/ocm_channel.v
// one output compare channel with a classic wishbone register slave
// What this block does
// - mode in ctrl1 bits 2:0, trigger select bit 3
// - select set: secondary match or software clears armed
// - select clear: only software clears armed flag
// - mode 111: high on primary, low on secondary
// - mode 110: high at zero, low on primary
// - mode 101: start low, toggle on alternate matches
// - mode 100: start low, one pulse only
// - mode 011: toggle on every primary match
// - mode 010: start high, low on primary
// - mode 001: start low, high on primary
// - mode 000: channel off, matches ignored
// - compare values double-buffered only in pwm modes
// - one sequencer trigger output clocks each channel
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ocm_map.vh"
module ocm_channel (
    // clock, reset and enable
    input  wire        clk,          // 250 MHz clock
    input  wire        rst_n,        // synchronous reset, active low
    input  wire        ce,           // clock enable, freezes all state when low
    // classic wishbone register slave
    input  wire        wb_cyc_i,     // wishbone cycle
    input  wire        wb_stb_i,     // wishbone strobe
    input  wire        wb_we_i,      // wishbone write enable
    input  wire [5:2]  wb_adr_i,     // wishbone word address
    input  wire [3:0]  wb_sel_i,     // wishbone byte selects
    input  wire [31:0] wb_dat_i,     // wishbone write data
    output reg  [31:0] wb_dat_o,     // wishbone read data
    output reg         wb_ack_o,     // wishbone acknowledge
    // timer step sources and channel outputs
    input  wire [3:0]  seq_trig,     // sequencer trigger outputs four to seven, pins
    input  wire        sys_tick,     // peripheral clock step, same domain
    output reg         compare_output_pin, // compare output
    output reg         irq           // level interrupt
);
    // control fields, compare values and their active copies
    reg  [2:0]  compare_mode_sel;
    reg         trigger_clear_select;
    reg         trigger_armed_flag;
    reg  [1:0]  src_sel_reg;
    reg         src_seq_reg;
    reg  [15:0] compare_primary_value;
    reg  [15:0] compare_secondary_value;
    reg  [15:0] pri_act_reg;
    reg  [15:0] sec_act_reg;
    reg  [15:0] compare_timer_count;
    reg  [15:0] period_reg;
    reg  [2:0]  status_reg;
    reg  [2:0]  mask_reg;
    reg         shot_done_reg;
    reg         phase_reg;

    // trigger synchroniser stages
    reg  [3:0]  trig_s1;
    reg  [3:0]  trig_s2;
    reg  [3:0]  trig_s3;
    reg  [3:0]  trig_stable;
    reg         trig_prev;

    // next values of the output state
    reg         pin_next;
    reg         shot_next;
    reg         phase_next;
    reg  [31:0] rd_mux;

    // bus decode; the registered ack blocks a second take of one request
    wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_req   = bus_req & wb_we_i & wb_sel_i[0];
    wire wr_hi    = bus_req & wb_we_i & wb_sel_i[1];
    wire pwm_mode = compare_mode_sel[2] & compare_mode_sel[1];
    wire off_mode = (compare_mode_sel == `OCM_MODE_OFF);
    wire wr_ctrl1 = wr_req & (wb_adr_i == `OCM_ADR_CTRL1);
    wire wr_ctrl2 = wr_req & (wb_adr_i == `OCM_ADR_CTRL2);

    // one write strobe per register lane
    wire wr_pri_lo = wr_req & (wb_adr_i == `OCM_ADR_PRIMARY);
    wire wr_pri_hi = wr_hi & (wb_adr_i == `OCM_ADR_PRIMARY);
    wire wr_sec_lo = wr_req & (wb_adr_i == `OCM_ADR_SECONDARY);
    wire wr_sec_hi = wr_hi & (wb_adr_i == `OCM_ADR_SECONDARY);
    wire wr_per_lo = wr_req & (wb_adr_i == `OCM_ADR_PERIOD);
    wire wr_per_hi = wr_hi & (wb_adr_i == `OCM_ADR_PERIOD);
    wire wr_mask   = wr_req & (wb_adr_i == `OCM_ADR_MASK);
    wire wr_stat   = wr_req & (wb_adr_i == `OCM_ADR_STATUS);

    // selected sequencer trigger as a level, rising edge is a timer step
    wire trig_sel = trig_stable[src_sel_reg];
    wire trig_rise = trig_sel & ~trig_prev;
    wire step     = src_seq_reg ? trig_rise : sys_tick;
    wire wrap     = step & (compare_timer_count == period_reg);
    wire m_pri    = step & (compare_timer_count == pri_act_reg);
    wire m_sec    = step & (compare_timer_count == sec_act_reg);
    wire m_zero   = step & (compare_timer_count == `OCM_ZERO16);

    // events of this step; the channel raises none while it is off
    wire [2:0] st_set    = off_mode ? 3'h0 : {wrap, m_sec, m_pri};
    wire [2:0] st_clr    = wr_stat ? wb_dat_i[2:0] : 3'h0;
    // pwm modes take new compare values only at the period wrap
    wire       load_act  = !pwm_mode || wrap || off_mode;
    // start level that a mode write reloads
    wire       start_lvl = (wb_dat_i[`OCM_MODE_MSB:`OCM_MODE_LSB] == `OCM_MODE_SS_LOW);

    // triple synchroniser, change taken when stages two and three agree
    always @(posedge clk) begin
        if (!rst_n) begin
            trig_s1     <= 4'h0;
            trig_s2     <= 4'h0;
            trig_s3     <= 4'h0;
            trig_stable <= 4'h0;
        end else if (ce) begin
            trig_s1     <= seq_trig;
            trig_s2     <= trig_s1;
            trig_s3     <= trig_s2;
            // agreement of stages two and three filters a one-cycle glitch
            trig_stable <= (trig_s2 & trig_s3) | (trig_stable & (trig_s2 | trig_s3));
        end
    end

    // last level of the selected trigger, for its rising edge
    always @(posedge clk) begin
        if (!rst_n) begin
            trig_prev <= 1'b0;
        end else if (ce) begin
            trig_prev <= trig_sel;
        end
    end

    // output and one-shot state per mode
    always @* begin
        pin_next   = compare_output_pin;
        shot_next  = shot_done_reg;
        phase_next = phase_reg;
        case (compare_mode_sel)
            `OCM_MODE_OFF: begin
                pin_next = 1'b0;
            end
            `OCM_MODE_SS_HIGH: begin
                if (m_pri) begin
                    pin_next = 1'b1;
                end
            end
            `OCM_MODE_SS_LOW: begin
                if (m_pri) begin
                    pin_next = 1'b0;
                end
            end
            `OCM_MODE_TOGGLE: begin
                if (m_pri) begin
                    pin_next = ~compare_output_pin;
                end
            end
            `OCM_MODE_DC_SHOT: begin
                if (!shot_done_reg && !phase_reg && m_pri) begin
                    pin_next   = 1'b1;
                    phase_next = 1'b1;
                end else if (!shot_done_reg && phase_reg && m_sec) begin
                    pin_next   = 1'b0;
                    phase_next = 1'b0;
                    shot_next  = 1'b1;
                end
            end
            `OCM_MODE_DC_CONT: begin
                if (!phase_reg && m_pri) begin
                    pin_next   = ~compare_output_pin;
                    phase_next = 1'b1;
                end else if (phase_reg && m_sec) begin
                    pin_next   = ~compare_output_pin;
                    phase_next = 1'b0;
                end
            end
            `OCM_MODE_PWM_EDGE: begin
                if (m_pri) begin
                    pin_next = 1'b0;
                end else if (m_zero) begin
                    pin_next = 1'b1;
                end
            end
            `OCM_MODE_PWM_CTR: begin
                if (m_sec) begin
                    pin_next = 1'b0;
                end else if (m_pri) begin
                    pin_next = 1'b1;
                end
            end
            default: begin
                pin_next = 1'b0;
            end
        endcase
    end

    // a mode write reloads the initial pin level and the one-shot state
    always @(posedge clk) begin
        if (!rst_n) begin
            compare_output_pin <= 1'b0;
            shot_done_reg      <= 1'b0;
            phase_reg          <= 1'b0;
        end else if (ce) begin
            if (wr_ctrl1) begin
                compare_output_pin <= start_lvl;
                shot_done_reg      <= 1'b0;
                phase_reg          <= 1'b0;
            end else begin
                compare_output_pin <= pin_next;
                shot_done_reg      <= shot_next;
                phase_reg          <= phase_next;
            end
        end
    end

    // timer, compare values and their active copies
    // the timer moves only on a step and wraps at the period; off mode holds it at zero
    always @(posedge clk) begin
        if (!rst_n) begin
            compare_timer_count <= `OCM_ZERO16;
            pri_act_reg         <= `OCM_ZERO16;
            sec_act_reg         <= `OCM_ZERO16;
        end else if (ce) begin
            if (off_mode) begin
                compare_timer_count <= `OCM_ZERO16;
            end else if (wrap) begin
                compare_timer_count <= `OCM_ZERO16;
            end else if (step) begin
                compare_timer_count <= compare_timer_count + `OCM_ONE16;
            end
            if (load_act) begin
                pri_act_reg <= compare_primary_value;
                sec_act_reg <= compare_secondary_value;
            end
        end
    end

    // register file
    always @(posedge clk) begin
        if (!rst_n) begin
            compare_mode_sel        <= `OCM_MODE_OFF;
            trigger_clear_select    <= 1'b0;
            trigger_armed_flag      <= 1'b0;
            src_sel_reg             <= 2'h0;
            src_seq_reg             <= 1'b0;
            compare_primary_value   <= `OCM_ZERO16;
            compare_secondary_value <= `OCM_ZERO16;
            period_reg              <= `OCM_PERIOD_RST;
            status_reg              <= 3'h0;
            mask_reg                <= 3'h0;
        end else if (ce) begin
            if (wr_ctrl1) begin
                compare_mode_sel     <= wb_dat_i[`OCM_MODE_MSB:`OCM_MODE_LSB];
                trigger_clear_select <= wb_dat_i[`OCM_TRIGSEL_BIT];
            end
            if (wr_ctrl2) begin
                src_sel_reg <= wb_dat_i[`OCM_SRC_MSB:`OCM_SRC_LSB];
                src_seq_reg <= wb_dat_i[`OCM_SRC_SEQ_BIT];
            end
            // software writes the flag; secondary match may clear it
            if (wr_ctrl2) begin
                trigger_armed_flag <= wb_dat_i[`OCM_ARMED_BIT];
            end else if (trigger_clear_select && m_sec && !off_mode) begin
                trigger_armed_flag <= 1'b0;
            end
            // compare values and period, each lane on its own
            if (wr_pri_lo) begin
                compare_primary_value[7:0] <= wb_dat_i[7:0];
            end
            if (wr_pri_hi) begin
                compare_primary_value[15:8] <= wb_dat_i[15:8];
            end
            if (wr_sec_lo) begin
                compare_secondary_value[7:0] <= wb_dat_i[7:0];
            end
            if (wr_sec_hi) begin
                compare_secondary_value[15:8] <= wb_dat_i[15:8];
            end
            if (wr_per_lo) begin
                period_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wr_per_hi) begin
                period_reg[15:8] <= wb_dat_i[15:8];
            end
            // mask and status
            if (wr_mask) begin
                mask_reg <= wb_dat_i[2:0];
            end
            // set wins over write-one-to-clear
            status_reg <= (status_reg & ~st_clr) | st_set;
        end
    end

    always @* begin
        rd_mux = `OCM_ZERO32;
        case (wb_adr_i)
            `OCM_ADR_CTRL1: begin
                rd_mux[3:0] = {trigger_clear_select, compare_mode_sel};
            end
            `OCM_ADR_CTRL2: begin
                rd_mux[6:0] = {trigger_armed_flag, 3'h0, src_seq_reg,
                               src_sel_reg};
            end
            `OCM_ADR_PRIMARY: begin
                rd_mux[15:0] = compare_primary_value;
            end
            `OCM_ADR_SECONDARY: begin
                rd_mux[15:0] = compare_secondary_value;
            end
            `OCM_ADR_TIMER: begin
                rd_mux[15:0] = compare_timer_count;
            end
            `OCM_ADR_STATUS: begin
                rd_mux[3:0] = {compare_output_pin, status_reg};
            end
            `OCM_ADR_MASK: begin
                rd_mux[2:0] = mask_reg;
            end
            `OCM_ADR_PERIOD: begin
                rd_mux[15:0] = period_reg;
            end
            default:            rd_mux = `OCM_ZERO32;
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `OCM_ZERO32;
        end else if (ce) begin
            // ack one cycle after the take, read data only beside it
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_mux : `OCM_ZERO32;
        end
    end

    // level interrupt from unmasked sticky status bits
    always @(posedge clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(status_reg & mask_reg);
        end
    end
endmodule // ocm_channel
`default_nettype wire

// ### src/ocm_map.vh
// register offsets, field positions and reset values of the compare channel
`ifndef OCM_MAP_VH
`define OCM_MAP_VH
`define OCM_ADR_CTRL1     4'h0
`define OCM_ADR_CTRL2     4'h1
`define OCM_ADR_PRIMARY   4'h2
`define OCM_ADR_SECONDARY 4'h3
`define OCM_ADR_TIMER     4'h4
`define OCM_ADR_STATUS    4'h5
`define OCM_ADR_MASK      4'h6
`define OCM_ADR_PERIOD    4'h7
`define OCM_MODE_MSB      2
`define OCM_MODE_LSB      0
`define OCM_TRIGSEL_BIT   3
`define OCM_ARMED_BIT     6
`define OCM_SRC_MSB       1
`define OCM_SRC_LSB       0
`define OCM_SRC_SEQ_BIT   2
`define OCM_MODE_OFF      3'h0
`define OCM_MODE_SS_HIGH  3'h1
`define OCM_MODE_SS_LOW   3'h2
`define OCM_MODE_TOGGLE   3'h3
`define OCM_MODE_DC_SHOT  3'h4
`define OCM_MODE_DC_CONT  3'h5
`define OCM_MODE_PWM_EDGE 3'h6
`define OCM_MODE_PWM_CTR  3'h7
`define OCM_ST_PRI        0
`define OCM_ST_SEC        1
`define OCM_ST_WRAP       2
`define OCM_ZERO16        16'h0000
`define OCM_ONE16         16'h0001
`define OCM_PERIOD_RST    16'hffff
`define OCM_ZERO32        32'h0000_0000
`endif

// ### tb/ocm_channel_assertions.sv
// concurrent checks on the compare channel ports
`timescale 1ns/1ps
`default_nettype none
module ocm_channel_assertions (
    input wire logic        clk,                // clock
    input wire logic        rst_n,              // reset, active low
    input wire logic        ce,                 // clock enable
    input wire logic        wb_cyc_i,           // cycle
    input wire logic        wb_stb_i,           // strobe
    input wire logic        wb_we_i,            // write
    input wire logic [5:2]  wb_adr_i,           // word index
    input wire logic [3:0]  wb_sel_i,           // lanes
    input wire logic [31:0] wb_dat_i,           // write data
    input wire logic [31:0] wb_dat_o,           // read data
    input wire logic        wb_ack_o,           // ack
    input wire logic        sys_tick,           // timer step
    input wire logic        compare_output_pin  // pin
);
    logic [2:0] mode_q;
    logic       src_q;
    wire take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce && wb_sel_i[0];
    wire cw   = take && wb_adr_i == 4'h0;
    // shadow of mode and step source, tracked from bus writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q <= 3'h0;
            src_q  <= 1'b0;
        end else begin
            if (cw) mode_q <= wb_dat_i[2:0];
            if (take && wb_adr_i == 4'h1) src_q <= wb_dat_i[2];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
    endsequence
    sequence ctrl_wr;
        cw;
    endsequence
    ack_answer_a: assert property (wb_req |=> wb_ack_o) else $error("no ack after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
    start_level_a: assert property (ctrl_wr |=> compare_output_pin == (mode_q == 3'h2))
        else $error("wrong start level");
    off_quiet_a: assert property (mode_q == 3'h0 |-> !compare_output_pin)
        else $error("pin active while off");
    shot_high_a: assert property (mode_q == 3'h1 && compare_output_pin && !cw |=>
        compare_output_pin) else $error("pin left high state");
    shot_low_a: assert property (mode_q == 3'h2 && !compare_output_pin && !cw |=>
        !compare_output_pin) else $error("pin left low state");
    step_cause_a: assert property (!src_q && $changed(compare_output_pin) |->
        $past(sys_tick) || $past(sys_tick, 2) || $past(cw)) else $error("pin moved without step");
endmodule // ocm_channel_assertions
bind ocm_channel ocm_channel_assertions i_ocm_channel_assertions (.clk(clk), .rst_n(rst_n),
    .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sys_tick(sys_tick), .compare_output_pin(compare_output_pin));
`default_nettype wire

// ### tb/ocm_seq_model.sv
// trigger sequencer outputs four to seven feeding the channel
`timescale 1ns/1ps
`default_nettype none
module ocm_seq_model (
    input  wire logic       clk,      // clock
    input  wire logic       fire,     // emit one trigger
    input  wire logic [1:0] line,     // output to drive
    input  wire logic [3:0] hold,     // cycles the pulse stands
    output var  logic [3:0] seq_trig  // trigger outputs, idle low
);
    logic [3:0] left = 4'h0;
    always @(posedge clk) begin
        if (fire) left <= hold;
        else if (left != 4'h0) left <= left - 4'h1;
    end
    always @* seq_trig = (left != 4'h0) ? (4'h1 << line) : 4'h0;
endmodule // ocm_seq_model
`default_nettype wire

// ### tb/output_compare_mode_logic_bench.sv
// self-checking bench for the compare channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module output_compare_mode_logic_bench;
    logic        clk, rst_n, cyc, stb, we, tick, ack, pin, irq, fire, pe, done, ts, ce_r;
    logic [3:0]  adr, trig, hold, sel;
    logic [1:0]  line;
    logic [31:0] dat, rd;
    logic [31:0] exp_q[$], msk_q[$];
    logic [15:0] pri, sec, c;
    int          seed, m, k, mismatches, total_checks;
    ocm_channel i_ocm_channel (.clk(clk), .rst_n(rst_n), .ce(ce_r), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rd), .wb_ack_o(ack), .seq_trig(trig), .sys_tick(tick),
        .compare_output_pin(pin), .irq(irq));
    ocm_seq_model i_ocm_seq_model (.clk(clk), .fire(fire), .line(line), .hold(hold),
        .seq_trig(trig));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, mk);
        if (!w) begin
            exp_q.push_back(d);
            msk_q.push_back(mk);
        end
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse(input logic [1:0] l);
        line <= l;
        hold <= 4'h3 + 4'($unsigned($random(seed)) % 6);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (14) @(posedge clk);
    endtask
    task automatic step;
        logic hp, hs;
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        repeat (2 + $unsigned($random(seed)) % 3) @(posedge clk);
        hp = (c == pri);
        hs = (c == sec);
        case (m)
            1: if (hp) pe = 1'b1;
            2: if (hp) pe = 1'b0;
            3: if (hp) pe = !pe;
            4: begin
                if (hp && !done) pe = 1'b1;
                if (hs && pe) {pe, done} = 2'b01;
            end
            5: if (hp || hs) pe = !pe;
            6: if (c == 16'h0) pe = 1'b1; else if (hp) pe = 1'b0;
            default: if (hp) pe = 1'b1; else if (hs) pe = 1'b0;
        endcase
        c = (c == 16'h7) ? 16'h0 : c + 16'h1;
        `CHK("pin", pe, pin)
    endtask
    // result watcher: read data against the oldest note
    always @(posedge clk) begin
        if (ack === 1'b1 && !we && exp_q.size() > 0) begin
            `CHK("read", exp_q[0] & msk_q[0], rd & msk_q[0])
            exp_q.delete(0);
            msk_q.delete(0);
        end
    end
    initial begin
        #40000;
        mismatches++;
        test_done;
    end
    initial begin
        {seed, mismatches, total_checks} = {32'd86, 32'd0, 32'd0};
        {rst_n, cyc, stb, we, tick, fire, adr, dat, line, hold} = '0;
        {ce_r, sel} = {1'b1, 4'h3};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(0, 4'h7, 32'hffff, 32'hffff);
        bus(0, 4'h0, 32'h0, 32'hf);
        bus(1, 4'h9, 32'h5a5a, 32'h0);
        bus(0, 4'h9, 32'h0, 32'hffff_ffff);
        bus(1, 4'h7, 32'h7, 32'h0);
        bus(1, 4'h6, 32'h1, 32'h0);
        for (m = 1; m < 8; m++) begin
            pri = 16'h1 + 16'($unsigned($random(seed)) % 3);
            sec = pri + 16'h2 + 16'($unsigned($random(seed)) % 2);
            ts = 1'($random(seed));
            bus(1, 4'h0, 32'h0, 32'h0);
            bus(1, 4'h2, {16'h0, pri}, 32'h0);
            bus(1, 4'h3, {16'h0, sec}, 32'h0);
            bus(1, 4'h1, 32'h40, 32'h0);
            bus(1, 4'h5, 32'h7, 32'h0);
            bus(1, 4'h0, {28'h0, ts, 3'(m)}, 32'h0);
            {pe, done, c} = {(m == 2), 1'b0, 16'h0};
            `CHK("start", pe, pin)
            for (k = 0; k < 10; k++) step;
            bus(0, 4'h5, {28'h0, pe, 3'h7}, 32'hf);
            bus(0, 4'h1, {25'h0, !ts, 6'h0}, 32'h40);
            `CHK("irq", 1'b1, irq)
        end
        bus(1, 4'h6, 32'h0, 32'h0);
        `CHK("irq masked", 1'b0, irq)
        bus(1, 4'h6, 32'h1, 32'h0);
        `CHK("irq raised", 1'b1, irq)
        bus(1, 4'h5, 32'h1, 32'h0);
        `CHK("irq cleared", 1'b0, irq)
        for (k = 0; k < 4; k++) begin
            bus(1, 4'h0, 32'h0, 32'h0);
            bus(1, 4'h0, 32'h3, 32'h0);
            bus(1, 4'h1, 32'h4 | k, 32'h0);
            pulse(2'(k + 1));
            bus(0, 4'h4, 32'h0, 32'hffff);
            pulse(2'(k));
            bus(0, 4'h4, 32'h1, 32'hffff);
        end
        bus(1, 4'h2, 32'h1234, 32'h0);
        sel <= 4'h2;
        bus(1, 4'h2, 32'hab00, 32'h0);
        sel <= 4'h3;
        bus(0, 4'h2, 32'hab34, 32'hffff);
        bus(1, 4'h1, 32'h0, 32'h0);
        {ce_r, tick} <= 2'b01;
        repeat (3) @(posedge clk);
        {ce_r, tick} <= 2'b10;
        @(posedge clk);
        bus(0, 4'h4, 32'h1, 32'hffff);
        test_done;
    end
endmodule // output_compare_mode_logic_bench
`default_nettype wire
